// ==== phy_status_pkg.sv ====
// constants for the autonegotiation result and live status registers
// assumes a clause 45 management frame on mdc/mdio pins
package phy_status_pkg;

    // management device addresses
    localparam logic [4:0]  DEVAD_AN        = 5'h07;
    localparam logic [4:0]  DEVAD_VS        = 5'h1e;

    // register addresses inside their devices
    localparam logic [15:0] ADDR_RESULT     = 16'h8001;
    localparam logic [15:0] ADDR_LIVE       = 16'h8030;
    localparam logic [15:0] ADDR_VENDOR     = 16'h0002;

    // reset values
    localparam logic [15:0] RESULT_RESET    = 16'h0000;
    localparam logic [15:0] LIVE_RESET      = 16'h0010;
    localparam logic [15:0] ADDR_RESET      = 16'h0000;

    // negotiation result field positions
    localparam int          TXLVL_LSB       = 7;
    localparam int          ROLE_LSB        = 5;
    localparam int          TECH_LSB        = 1;
    localparam int          DONE_BIT        = 0;

    // live status bit positions
    localparam int          TXEN_BIT        = 4;
    localparam int          MASTER_BIT      = 3;
    localparam int          SLAVE_BIT       = 2;
    localparam int          HI_BIT          = 1;
    localparam int          LO_BIT          = 0;

    // field encodings
    localparam logic [1:0]  TXLVL_NOT_RUN   = 2'h0;
    localparam logic [1:0]  TXLVL_LOW       = 2'h2;
    localparam logic [1:0]  TXLVL_HIGH      = 2'h3;
    localparam logic [1:0]  ROLE_NOT_RUN    = 2'h0;
    localparam logic [1:0]  ROLE_FAULT      = 2'h1;
    localparam logic [1:0]  ROLE_SLAVE      = 2'h2;
    localparam logic [1:0]  ROLE_MASTER     = 2'h3;
    localparam logic [3:0]  TECH_NONE       = 4'h0;
    localparam logic [3:0]  TECH_10T1L      = 4'h1;

    // frame opcodes
    localparam logic [1:0]  OP_ADDR         = 2'h0;
    localparam logic [1:0]  OP_WRITE        = 2'h1;
    localparam logic [1:0]  OP_READ_INC     = 2'h2;
    localparam logic [1:0]  OP_READ         = 2'h3;

    // frame bit counts
    localparam logic [5:0]  PREAMBLE_BITS   = 6'h20;
    localparam logic [5:0]  HEAD_LAST       = 6'h0b;
    localparam logic [5:0]  DATA_LAST       = 6'h0f;

endpackage : phy_status_pkg

// ==== pin_sync2.sv ====
// two-flop synchroniser for asynchronous pins
// assumes a synchronous active-high reset on the sampling clock
`timescale 1ns/1ps
`default_nettype none

module pin_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             reset_i,
    // pins in, synchronised out
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("pin_sync2 needs WIDTH of at least one");
        end
    endgenerate

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] q_next;

    always_comb begin
        meta_next = d_i;
        q_next    = meta_reg;
    end

    // meta_reg feeds only q_o
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            meta_reg <= '0;
            q_o      <= '0;
        end else begin
            meta_reg <= meta_next;
            q_o      <= q_next;
        end
    end

endmodule : pin_sync2

`default_nettype wire

// ==== autoneg_result_status_regs.sv ====
// autonegotiation result, live status and vendor id registers, read
// through a clause 45 management slave on mdc/mdio
// assumes status inputs come from logic on core_clk_i and mdc runs at
// most a quarter of core_clk_i
// Contract
// [RQ1] result bits 8:7 hold tx level: 0 not run, 2 low, 3 high swing.
// [RQ2] result bits 6:5 hold role: 0 not run, 1 fault, 2 slave, 3 master.
// [RQ3] result bits 4:1 hold common technology: 0 none, 1 10BASE-T1L.
// [RQ4] result bit 0 marks negotiation done with the chosen link coming up.
// [RQ5] live word 0x8030 returns unlatched bits captured in one cycle.
// [RQ6] live bit 4 is high while negotiation drives tx; it resets to one.
// [RQ7] with link control on, exactly one of live master or slave is set.
// [RQ8] live bit 1 marks high swing and live bit 0 low swing operation.
// [RQ9] a read-only vendor id word sits at 0x0002 of device 0x1e.
// [RQ10] result word at 0x8001 of device 0x07, reset value zero.
// [RQ11] reads clear nothing and change no status field.
`timescale 1ns/1ps
`default_nettype none

module autoneg_result_status_regs
    import phy_status_pkg::*;
#(
    parameter logic [4:0]  PHY_ADDR       = 5'h00,
    // arbitrary value, stands in for the real identifier
    parameter logic [15:0] VENDOR_ID_HIGH = 16'h5a3c
) (
    // clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       reset_i,
    // management pins
    input  wire logic       mdc_i,
    input  wire logic       mdio_i,
    output logic            mdio_o,
    output logic            mdio_oe_o,
    // negotiation results
    input  wire logic [1:0] tx_level_result_i,
    input  wire logic [1:0] role_result_i,
    input  wire logic [3:0] common_technology_i,
    input  wire logic       negotiation_done_i,
    // live operating state
    input  wire logic       negotiation_drives_tx_i,
    input  wire logic       link_control_enable_i,
    input  wire logic       operating_master_i,
    input  wire logic       operating_high_swing_i
);

    generate
        if (PREAMBLE_BITS == 6'h00) begin : g_bad_preamble
            $error("preamble length must be nonzero");
        end
    endgenerate

    typedef enum logic [2:0] {
        S_PREAMBLE,
        S_START,
        S_HEAD,
        S_TURN,
        S_DATA
    } frame_state_e;

    logic [1:0]   pins_s;
    logic         mdc_s;
    logic         mdio_s;
    logic         mdc_rise;

    frame_state_e state_reg,     state_next;
    logic [5:0]   cnt_reg,       cnt_next;
    logic [11:0]  hdr_reg,       hdr_next;
    logic [1:0]   op_reg,        op_next;
    logic         respond_reg,   respond_next;
    logic         devsel_reg,    devsel_next;
    logic [15:0]  in_reg,        in_next;
    logic [15:0]  shift_reg,     shift_next;
    logic [15:0]  addr_an_reg,   addr_an_next;
    logic [15:0]  addr_vs_reg,   addr_vs_next;
    logic         mdc_d_reg;
    logic         mdio_next;
    logic         oe_next;
    logic [15:0]  result_reg,    result_next;
    logic [15:0]  live_reg,      live_next;
    logic [11:0]  hdr_full;
    logic [15:0]  cur_addr;
    logic         snap;

    pin_sync2 #(
        .WIDTH      (2)
    ) u_pin_sync (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .d_i        ({mdc_i, mdio_i}),
        .q_o        (pins_s)
    );

    assign mdc_s    = pins_s[1];
    assign mdio_s   = pins_s[0];
    assign mdc_rise = mdc_s & ~mdc_d_reg;
    assign hdr_full = {hdr_reg[10:0], mdio_s};
    assign cur_addr = devsel_reg ? addr_vs_reg : addr_an_reg;
    assign snap     = mdc_rise && (state_reg == S_TURN) &&
                      (cnt_reg == 6'h00) && respond_reg && op_reg[1];

    function automatic logic [15:0] reg_select(
        input logic        vs,
        input logic [15:0] addr,
        input logic [15:0] result,
        input logic [15:0] live
    );
        logic [15:0] rd;
        rd = 16'h0000;
        if (vs) begin
            if (addr == ADDR_VENDOR) begin
                rd = VENDOR_ID_HIGH; // see [RQ9]
            end
        end else if (addr == ADDR_RESULT) begin
            rd = result; // see [RQ10]
        end else if (addr == ADDR_LIVE) begin
            rd = live; // see [RQ5]
        end
        return rd;
    endfunction : reg_select

    // status capture; free-running so a read never alters it, see [RQ11]
    always_comb begin
        result_next                    = RESULT_RESET;
        result_next[TXLVL_LSB +: 2]    = tx_level_result_i; // see [RQ1]
        result_next[ROLE_LSB +: 2]     = role_result_i; // see [RQ2]
        result_next[TECH_LSB +: 4]     = common_technology_i; // see [RQ3]
        result_next[DONE_BIT]          = negotiation_done_i; // see [RQ4]
        live_next                      = 16'h0000;
        live_next[TXEN_BIT]            = negotiation_drives_tx_i; // see [RQ6]
        live_next[MASTER_BIT]          = link_control_enable_i &
                                         operating_master_i; // see [RQ7]
        live_next[SLAVE_BIT]           = link_control_enable_i &
                                         ~operating_master_i; // see [RQ7]
        live_next[HI_BIT]              = operating_high_swing_i; // see [RQ8]
        live_next[LO_BIT]              = ~operating_high_swing_i; // see [RQ8]
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            result_reg <= RESULT_RESET; // see [RQ10]
            live_reg   <= LIVE_RESET; // see [RQ6]
        end else begin
            result_reg <= result_next;
            live_reg   <= live_next;
        end
    end

    // frame engine; acts only on synchronised mdc rising edges
    always_comb begin
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        hdr_next     = hdr_reg;
        op_next      = op_reg;
        respond_next = respond_reg;
        devsel_next  = devsel_reg;
        in_next      = in_reg;
        shift_next   = shift_reg;
        addr_an_next = addr_an_reg;
        addr_vs_next = addr_vs_reg;
        mdio_next    = mdio_o;
        oe_next      = mdio_oe_o;
        if (mdc_rise) begin
            unique case (state_reg)
                S_PREAMBLE: begin
                    if (mdio_s) begin
                        if (cnt_reg != PREAMBLE_BITS) begin
                            cnt_next = 6'(cnt_reg + 6'h01);
                        end
                    end else if (cnt_reg == PREAMBLE_BITS) begin
                        state_next = S_START;
                    end else begin
                        cnt_next = 6'h00;
                    end
                end
                S_START: begin
                    // a one here is a clause 22 start, not ours
                    cnt_next   = 6'h00;
                    state_next = mdio_s ? S_PREAMBLE : S_HEAD;
                end
                S_HEAD: begin
                    hdr_next = hdr_full;
                    if (cnt_reg == HEAD_LAST) begin
                        op_next      = hdr_full[11:10];
                        devsel_next  = (hdr_full[4:0] == DEVAD_VS);
                        respond_next = (hdr_full[9:5] == PHY_ADDR) &&
                                       ((hdr_full[4:0] == DEVAD_AN) ||
                                        (hdr_full[4:0] == DEVAD_VS));
                        cnt_next     = 6'h00;
                        state_next   = S_TURN;
                    end else begin
                        cnt_next = 6'(cnt_reg + 6'h01);
                    end
                end
                S_TURN: begin
                    if (cnt_reg == 6'h00) begin
                        cnt_next = 6'h01;
                        if (respond_reg && op_reg[1]) begin
                            // whole word taken in one cycle, see [RQ5]
                            shift_next = reg_select(devsel_reg, cur_addr,
                                                    result_reg, live_reg);
                            oe_next    = 1'b1;
                            mdio_next  = 1'b0;
                        end
                    end else begin
                        cnt_next   = 6'h00;
                        state_next = S_DATA;
                        if (respond_reg && op_reg[1]) begin
                            mdio_next  = shift_reg[15];
                            shift_next = {shift_reg[14:0], 1'b0};
                        end
                    end
                end
                S_DATA: begin
                    in_next = {in_reg[14:0], mdio_s};
                    if (cnt_reg == DATA_LAST) begin
                        oe_next    = 1'b0;
                        mdio_next  = 1'b0;
                        cnt_next   = 6'h00;
                        state_next = S_PREAMBLE;
                        // writes to these read-only words are dropped
                        if (respond_reg && (op_reg == OP_ADDR)) begin
                            if (devsel_reg) begin
                                addr_vs_next = in_next;
                            end else begin
                                addr_an_next = in_next;
                            end
                        end
                        if (respond_reg && (op_reg == OP_READ_INC)) begin
                            if (devsel_reg) begin
                                addr_vs_next = 16'(addr_vs_reg + 16'h0001);
                            end else begin
                                addr_an_next = 16'(addr_an_reg + 16'h0001);
                            end
                        end
                    end else begin
                        cnt_next = 6'(cnt_reg + 6'h01);
                        if (respond_reg && op_reg[1]) begin
                            mdio_next  = shift_reg[15];
                            shift_next = {shift_reg[14:0], 1'b0};
                        end
                    end
                end
                default: begin
                    state_next = S_PREAMBLE;
                    cnt_next   = 6'h00;
                    oe_next    = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_reg   <= S_PREAMBLE;
            cnt_reg     <= 6'h00;
            hdr_reg     <= 12'h000;
            op_reg      <= OP_READ;
            respond_reg <= 1'b0;
            devsel_reg  <= 1'b0;
            in_reg      <= 16'h0000;
            shift_reg   <= 16'h0000;
            addr_an_reg <= ADDR_RESET;
            addr_vs_reg <= ADDR_RESET;
            mdc_d_reg   <= 1'b0;
            mdio_o      <= 1'b0;
            mdio_oe_o   <= 1'b0;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            hdr_reg     <= hdr_next;
            op_reg      <= op_next;
            respond_reg <= respond_next;
            devsel_reg  <= devsel_next;
            in_reg      <= in_next;
            shift_reg   <= shift_next;
            addr_an_reg <= addr_an_next;
            addr_vs_reg <= addr_vs_next;
            mdc_d_reg   <= mdc_s;
            mdio_o      <= mdio_next;
            mdio_oe_o   <= oe_next;
        end
    end

    a_result_fields: assert property (@(posedge core_clk_i) // see [RQ1]
        disable iff (reset_i) 1 |=> result_reg[8:0] == $past({
            tx_level_result_i, role_result_i, common_technology_i,
            negotiation_done_i})
    ) else $error("result fields do not follow resolution");
    a_result_reset: assert property (@(posedge core_clk_i) // see [RQ10]
        $fell(reset_i) |-> (result_reg == 16'h0000) && (live_reg == 16'h0010)
    ) else $error("status reset values wrong");
    a_done_follows: assert property (@(posedge core_clk_i) // see [RQ4]
        disable iff (reset_i) negotiation_done_i |=> result_reg[0]
    ) else $error("done bit missing");

    a_drives_tx: assert property (@(posedge core_clk_i) // see [RQ6]
        disable iff (reset_i) negotiation_drives_tx_i |=> live_reg[4]
    ) else $error("drives tx bit not set");
    a_one_role: assert property (@(posedge core_clk_i) // see [RQ7]
        disable iff (reset_i) link_control_enable_i |=> (^live_reg[3:2])
    ) else $error("not exactly one role bit");
    a_no_role: assert property (@(posedge core_clk_i) // see [RQ7]
        disable iff (reset_i) !link_control_enable_i |=> live_reg[3:2] == 2'h0
    ) else $error("role bit without link control");
    a_swing_pair: assert property (@(posedge core_clk_i) // see [RQ8]
        disable iff (reset_i) $past(!reset_i) |-> (^live_reg[1:0])
    ) else $error("swing bits not exclusive");

    a_live_snap: assert property (@(posedge core_clk_i) // see [RQ5]
        disable iff (reset_i) snap && !devsel_reg && (cur_addr == 16'h8030)
            |=> shift_reg == $past(live_reg)
    ) else $error("live word not captured whole");
    a_result_read: assert property (@(posedge core_clk_i) // see [RQ10]
        disable iff (reset_i) snap && !devsel_reg && (cur_addr == 16'h8001)
            |=> shift_reg == $past(result_reg)
    ) else $error("result word wrong on read");
    a_vendor_read: assert property (@(posedge core_clk_i) // see [RQ9]
        disable iff (reset_i) snap && devsel_reg && (cur_addr == 16'h0002)
            |=> shift_reg == VENDOR_ID_HIGH
    ) else $error("vendor word wrong on read");

    a_read_clean: assert property (@(posedge core_clk_i) // see [RQ11]
        disable iff (reset_i) snap ##1 $stable(live_next) |=> $stable(live_reg)
    ) else $error("read disturbed live status");

    a_turn_zero: assert property (@(posedge core_clk_i) // see [RQ5]
        disable iff (reset_i) $rose(mdio_oe_o) |-> !mdio_o &&
            (state_reg == S_TURN) && (cnt_reg == 6'h01)
    ) else $error("turnaround not driven low");
    a_oe_release: assert property (@(posedge core_clk_i) // see [RQ5]
        disable iff (reset_i) mdc_rise && (state_reg == S_DATA) &&
            (cnt_reg == 6'h0f) |=> !mdio_oe_o
    ) else $error("mdio not released after data");

endmodule : autoneg_result_status_regs

`default_nettype wire

// ==== mdio_host_model.sv ====
// station management host model: drives mdc and mdio for clause 45 frames
// assumes the bench resolves the mdio wire with a pull-up when released
`timescale 1ns/1ps
`default_nettype none

module mdio_host_model #(
    parameter int HALF = 5
) (
    // time base
    input  wire logic core_clk_i,
    // management pins
    output logic      mdc_o,
    output logic      mdio_o,
    output logic      mdio_oe_o,
    input  wire logic mdio_i
);
    // five core cycles a half keeps mdc at 1 mhz, well inside the limit
    initial begin
        mdc_o     = 1'b0;
        mdio_o    = 1'b1;
        mdio_oe_o = 1'b0;
    end

    // data changes while mdc is low and holds across the rising edge
    task automatic bit_cycle(input logic drive, input logic b,
                             output logic s);
        mdc_o     = 1'b0;
        mdio_oe_o = drive;
        mdio_o    = b;
        repeat (HALF) @(negedge core_clk_i);
        mdc_o = 1'b1;
        s     = mdio_i;
        repeat (HALF) @(negedge core_clk_i);
    endtask : bit_cycle

    // full preamble every frame; reads release the wire from turnaround on
    task automatic frame(input logic [1:0] op, input logic [4:0] prtad,
                         input logic [4:0] devad, input logic [15:0] wdata,
                         output logic [15:0] rdata, output logic ta2);
        logic [13:0] head;
        logic        s;
        logic        rd;
        rd   = op[1];
        head = {2'b00, op, prtad, devad};
        for (int i = 0; i < 32; i++) bit_cycle(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) bit_cycle(1'b1, head[i], s);
        bit_cycle(!rd, 1'b1, s);
        bit_cycle(!rd, 1'b0, ta2);
        for (int i = 15; i >= 0; i--) begin
            bit_cycle(!rd, wdata[i], s);
            rdata[i] = s;
        end
        // clock stands still low between frames; idle gap before the next
        mdc_o     = 1'b0;
        mdio_oe_o = 1'b0;
        repeat (HALF) @(negedge core_clk_i);
    endtask : frame
endmodule : mdio_host_model
`default_nettype wire

// ==== autoneg_result_status_regs_tb_top.sv ====
// self-checking bench for the negotiation result and live status registers
// assumes a pull-up on mdio and the host model driving mdc
`timescale 1ns/1ps
`default_nettype none

module autoneg_result_status_regs_tb_top;
    import phy_status_pkg::*;

    localparam logic [4:0]  PHY   = 5'h05;
    // arbitrary value, stands in for the real identifier
    localparam logic [15:0] VID   = 16'h3c5a;
    localparam int          LIMIT = 40000;

    logic        core_clk  = 1'b0;
    logic        reset_i   = 1'b1;
    logic [1:0]  tx_level  = 2'h0;
    logic [1:0]  role      = 2'h0;
    logic [3:0]  tech      = 4'h0;
    logic        done      = 1'b0;
    logic        drives_tx = 1'b1;
    logic        lce       = 1'b0;
    logic        master    = 1'b0;
    logic        high      = 1'b0;
    logic        mdc;
    logic        host_d;
    logic        host_oe;
    logic        dut_d;
    logic        dut_oe;
    wire logic   mdio_wire;
    logic [15:0] v;
    logic        ta;
    int          err_count    = 0;
    int          total_checks = 0;
    int          cycles       = 0;
    logic [8:0]  res_tab [5]  = '{9'h000, 9'h123, 9'h1c1, 9'h1e2, 9'h01e};
    logic [3:0]  live_tab [5] = '{4'h8, 4'h7, 4'h5, 4'hc, 4'ha};

    // released wire floats to the pull-up level
    assign mdio_wire = dut_oe ? dut_d : (host_oe ? host_d : 1'b1);

    always #50 core_clk = ~core_clk;

    autoneg_result_status_regs #(
        .PHY_ADDR       (PHY),
        .VENDOR_ID_HIGH (VID)
    ) dut (
        .core_clk_i              (core_clk),
        .reset_i                 (reset_i),
        .mdc_i                   (mdc),
        .mdio_i                  (mdio_wire),
        .mdio_o                  (dut_d),
        .mdio_oe_o               (dut_oe),
        .tx_level_result_i       (tx_level),
        .role_result_i           (role),
        .common_technology_i     (tech),
        .negotiation_done_i      (done),
        .negotiation_drives_tx_i (drives_tx),
        .link_control_enable_i   (lce),
        .operating_master_i      (master),
        .operating_high_swing_i  (high)
    );

    mdio_host_model host (
        .core_clk_i (core_clk),
        .mdc_o      (mdc),
        .mdio_o     (host_d),
        .mdio_oe_o  (host_oe),
        .mdio_i     (mdio_wire)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask : check

    task automatic set_addr(input logic [4:0] devad, input logic [15:0] a);
        logic [15:0] d;
        logic        t;
        host.frame(OP_ADDR, PHY, devad, a, d, t);
    endtask : set_addr

    task automatic rd(input logic [1:0] op, input logic [4:0] prtad,
                      input logic [4:0] devad);
        host.frame(op, prtad, devad, 16'h0000, v, ta);
    endtask : rd

    // live bits as the register defines them
    function automatic logic [15:0] live_exp(input logic [3:0] r);
        return {11'h000, r[3], r[2] & r[1], r[2] & ~r[1], r[0], ~r[0]};
    endfunction : live_exp

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_count++;
            $display("MISMATCH at %0t: run did not finish", $time);
            print_verdict();
        end
    end

    initial begin
        repeat (8) @(negedge core_clk);
        reset_i = 1'b0;
        repeat (4) @(negedge core_clk);

        set_addr(DEVAD_AN, ADDR_RESULT);
        for (int i = 0; i < 5; i++) begin
            {tx_level, role, tech, done} = res_tab[i];
            rd(OP_READ, PHY, DEVAD_AN);
            check(v, 16'(res_tab[i]), "result");
            check({15'h0000, ta}, 16'h0000, "turnaround");
        end
        $display("test done: result codes");

        // increment moves to an empty address; nothing gets cleared
        {tx_level, role, tech, done} = res_tab[1];
        rd(OP_READ_INC, PHY, DEVAD_AN);
        check(v, 16'h0123, "read inc");
        rd(OP_READ, PHY, DEVAD_AN);
        check(v, 16'h0000, "unmapped");
        set_addr(DEVAD_AN, ADDR_RESULT);
        rd(OP_READ, PHY, DEVAD_AN);
        check(v, 16'h0123, "reread");
        $display("test done: increment and reread");

        set_addr(DEVAD_AN, ADDR_LIVE);
        for (int i = 0; i < 5; i++) begin
            {drives_tx, lce, master, high} = live_tab[i];
            rd(OP_READ, PHY, DEVAD_AN);
            check(v, live_exp(live_tab[i]), "live");
        end
        $display("test done: live bits");

        // inputs change in mid-data; the word must stay one snapshot
        {drives_tx, lce, master, high} = 4'h7;
        fork
            rd(OP_READ, PHY, DEVAD_AN);
            begin
                repeat (560) @(negedge core_clk);
                {drives_tx, lce, master, high} = 4'hc;
            end
        join
        check(v, live_exp(4'h7), "snapshot");
        rd(OP_READ, PHY, DEVAD_AN);
        check(v, live_exp(4'hc), "after change");
        $display("test done: snapshot");

        set_addr(DEVAD_VS, ADDR_VENDOR);
        rd(OP_READ, PHY, DEVAD_VS);
        check(v, VID, "vendor");
        host.frame(OP_WRITE, PHY, DEVAD_VS, 16'h0000, v, ta);
        rd(OP_READ, PHY, DEVAD_VS);
        check(v, VID, "vendor after write");
        $display("test done: vendor id");

        // other station or device: wire stays at the pull-up
        rd(OP_READ, PHY ^ 5'h01, DEVAD_AN);
        check(v, 16'hffff, "other prtad");
        rd(OP_READ, PHY, 5'h01);
        check({v[15:1], ta}, 16'hffff, "other devad");
        $display("test done: address filter");

        print_verdict();
    end
endmodule : autoneg_result_status_regs_tb_top
`default_nettype wire
